// ---- src/dca_pkg.sv ----
// dca_pkg: constants, modes, states and carriers of the channel controller.
// assumes one system clock; the control table lives in system memory.
package dca_pkg;

  // ==========================================================
  // channel set
  localparam int CH_N = 8;
  localparam int CH_W = 3;

  // ==========================================================
  // register byte offsets on the slave port
  localparam logic [7:0] REG_BASE    = 8'h00;
  localparam logic [7:0] REG_EN_SET  = 8'h04;
  localparam logic [7:0] REG_EN_CLR  = 8'h08;
  localparam logic [7:0] REG_PRI_SET = 8'h0C;
  localparam logic [7:0] REG_PRI_CLR = 8'h10;
  localparam logic [7:0] REG_BO_SET  = 8'h14;
  localparam logic [7:0] REG_BO_CLR  = 8'h18;
  localparam logic [7:0] REG_ALT_SET = 8'h1C;
  localparam logic [7:0] REG_ALT_CLR = 8'h20;
  localparam logic [7:0] REG_STATUS  = 8'h24;

  // ==========================================================
  // control table layout
  localparam int          BASE_LSB  = 8;
  localparam int          ENTRY_LSB = 4;
  localparam logic [31:0] TBL_HALF  = 32'h0000_0080;
  localparam logic [31:0] OFF_SRC   = 32'h0000_0000;
  localparam logic [31:0] OFF_DST   = 32'h0000_0004;
  localparam logic [31:0] OFF_CTL   = 32'h0000_0008;

  // ==========================================================
  // control word fields
  localparam int CW_MODE_LSB = 0;
  localparam int CW_MODE_W   = 3;
  localparam int CW_UB_BIT   = 3;
  localparam int CW_NM1_LSB  = 4;
  localparam int CW_NM1_W    = 10;
  localparam int CW_ARB_LSB  = 14;
  localparam int CW_ARB_W    = 4;
  localparam int CW_SSZ_LSB  = 24;
  localparam int CW_SINC_LSB = 26;
  localparam int CW_DSZ_LSB  = 28;
  localparam int CW_DINC_LSB = 30;

  localparam logic [3:0]  ARB_EXP_MAX = 4'hA;
  localparam logic [1:0]  SZ_BYTE     = 2'h0;
  localparam logic [1:0]  SZ_HALF     = 2'h1;
  localparam logic [1:0]  INC_NONE    = 2'h3;
  localparam logic [10:0] CNT_ONE     = 11'h001;

  typedef enum logic [2:0] {
    MODE_STOP  = 3'b000,
    MODE_BASIC = 3'b001,
    MODE_AUTO  = 3'b010
  } dca_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RD_CTL = 3'b001,
    ST_RD_SRC = 3'b010,
    ST_RD_DST = 3'b011,
    ST_RD_DAT = 3'b100,
    ST_WR_DAT = 3'b101,
    ST_WB     = 3'b110
  } dca_fsm_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } dca_mm_req_t;

  typedef struct packed {
    logic [CH_N-1:0] burst;
    logic [CH_N-1:0] single;
  } dca_req_t;

endpackage

// ---- src/dca_ctrl.sv ----
// dca_ctrl: eight-channel dma core: arbitration, requests, control table.
// assumes an Avalon-MM slave for registers, an Avalon-MM master to memory
// without readdatavalid, and a processor busy level on the same clock.
`timescale 1ns/10ps

module dca_ctrl (
  // clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  // register slave
  input  wire logic [7:0]            s_address_i,
  input  wire logic                  s_read_i,
  input  wire logic                  s_write_i,
  input  wire logic [31:0]           s_writedata_i,
  output logic      [31:0]           s_readdata_o,
  output logic                       s_waitrequest_o,
  // memory master
  output dca_pkg::dca_mm_req_t       m_req_o,
  input  wire logic [31:0]           m_readdata_i,
  input  wire logic                  m_waitrequest_i,
  input  wire logic                  cpu_bus_req_i,
  // peripheral side
  input  wire dca_pkg::dca_req_t     req_i,
  output logic [dca_pkg::CH_N-1:0]   done_o
);
  import dca_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    dca_fsm_t        fsm;
    logic            s_wait;
    logic [31:0]     s_rdata;
    logic [23:0]     base;
    logic [CH_N-1:0] en;
    logic [CH_N-1:0] pri;
    logic [CH_N-1:0] bonly;
    logic [CH_N-1:0] alt;
    logic [CH_N-1:0] done;
    logic [CH_W-1:0] ch;
    logic            burst;
    logic [10:0]     left;
    logic [31:0]     ctl;
    logic [31:0]     src_end;
    logic [31:0]     dst_end;
    logic [31:0]     data;
    dca_mm_req_t     mm;
    dca_req_t        sync1;
    dca_req_t        sync2;
  } dca_state_t;

  dca_state_t st;
  dca_state_t next_st;

  // lowest number wins; high level searched first
  function automatic logic [CH_W:0] dca_pick(input logic [CH_N-1:0] p,
                                             input logic [CH_N-1:0] hi);
    logic [CH_N-1:0] h;
    logic [CH_N-1:0] s;
    logic [CH_W:0]   r;
    h = p & hi;
    s = (|h) ? h : p;
    r = '0;
    for (int i = CH_N - 1; i >= 0; i--) begin
      if (s[i]) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] dca_lanes(input logic [1:0] sz);
    case (sz)
      SZ_BYTE: dca_lanes = 4'h1;
      SZ_HALF: dca_lanes = 4'h3;
      default: dca_lanes = 4'hF;
    endcase
  endfunction

  // ==========================================================
  // decoded control word and addresses
  logic [CH_N-1:0] pend;
  logic [CH_W:0]   grant;
  logic [31:0]     entry;
  logic [9:0]      nm1;
  logic [1:0]      ssz;
  logic [1:0]      dsz;
  logic [1:0]      sinc;
  logic [1:0]      dinc;
  logic [3:0]      arb_exp;
  logic [10:0]     arb_cnt;
  logic [10:0]     remain;
  logic [31:0]     saddr;
  logic [31:0]     daddr;
  logic [31:0]     item;
  logic            ack;
  logic            acc_state;

  always_comb begin
    pend  = st.en & (st.sync2.burst | (st.sync2.single & ~st.bonly));
    grant = dca_pick(pend, st.pri);
    entry = {st.base, 8'h00} + {{(32-CH_W-ENTRY_LSB){1'b0}}, st.ch,
            {ENTRY_LSB{1'b0}}};
    if (st.alt[st.ch]) begin
      entry = entry + TBL_HALF;
    end
    nm1     = st.ctl[CW_NM1_LSB +: CW_NM1_W];
    ssz     = st.ctl[CW_SSZ_LSB +: 2];
    dsz     = st.ctl[CW_DSZ_LSB +: 2];
    sinc    = st.ctl[CW_SINC_LSB +: 2];
    dinc    = st.ctl[CW_DINC_LSB +: 2];
    arb_exp = st.ctl[CW_ARB_LSB +: CW_ARB_W];
    if (arb_exp > ARB_EXP_MAX) begin
      arb_exp = ARB_EXP_MAX;
    end
    arb_cnt = CNT_ONE << arb_exp;
    remain  = {1'b0, nm1} + CNT_ONE;
    // inclusive end minus the items left after this one; fixed when no increment
    saddr = st.src_end;
    daddr = st.dst_end;
    if (sinc != INC_NONE) begin
      saddr = st.src_end - ({22'h00_0000, nm1} << sinc);
    end
    if (dinc != INC_NONE) begin
      daddr = st.dst_end - ({22'h00_0000, nm1} << dinc);
    end
    item = m_readdata_i >> {saddr[1:0], 3'b000};
    case (ssz)
      SZ_BYTE: item = item & 32'h0000_00FF;
      SZ_HALF: item = item & 32'h0000_FFFF;
      default: item = item;
    endcase
    ack       = (st.mm.read | st.mm.write) & ~m_waitrequest_i;
    acc_state = (st.fsm != ST_IDLE);
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st       = st;
    next_st.sync1 = req_i;
    next_st.sync2 = st.sync1;
    next_st.done  = '0;
    next_st.s_wait = 1'b1;

    // new access only while the processor leaves the bus alone
    if (acc_state && !st.mm.read && !st.mm.write && !cpu_bus_req_i) begin
      next_st.mm.byteenable = 4'hF;
      case (st.fsm)
        ST_RD_CTL: begin
          next_st.mm.read    = 1'b1;
          next_st.mm.address = entry + OFF_CTL;
        end
        ST_RD_SRC: begin
          next_st.mm.read    = 1'b1;
          next_st.mm.address = entry + OFF_SRC;
        end
        ST_RD_DST: begin
          next_st.mm.read    = 1'b1;
          next_st.mm.address = entry + OFF_DST;
        end
        ST_RD_DAT: begin
          next_st.mm.read       = 1'b1;
          next_st.mm.address    = {saddr[31:2], 2'b00};
          next_st.mm.byteenable = dca_lanes(ssz) << saddr[1:0];
        end
        ST_WR_DAT: begin
          next_st.mm.write      = 1'b1;
          next_st.mm.address    = {daddr[31:2], 2'b00};
          next_st.mm.writedata  = st.data << {daddr[1:0], 3'b000};
          next_st.mm.byteenable = dca_lanes(dsz) << daddr[1:0];
        end
        default: begin
          // only the control word goes back, never the end pointers
          next_st.mm.write     = 1'b1;
          next_st.mm.address   = entry + OFF_CTL;
          next_st.mm.writedata = st.ctl;
        end
      endcase
    end

    if (ack) begin
      next_st.mm.read  = 1'b0;
      next_st.mm.write = 1'b0;
    end

    case (st.fsm)
      ST_IDLE: begin
        if (grant[CH_W]) begin
          next_st.ch    = grant[CH_W-1:0];
          next_st.burst = st.sync2.burst[grant[CH_W-1:0]];
          next_st.fsm   = ST_RD_CTL;
        end
      end
      ST_RD_CTL: begin
        if (ack) begin
          next_st.ctl = m_readdata_i;
          if (m_readdata_i[CW_MODE_LSB +: CW_MODE_W] == MODE_STOP) begin
            next_st.en[st.ch] = 1'b0;
            next_st.fsm       = ST_IDLE;
          end else if (!st.burst && m_readdata_i[CW_UB_BIT]) begin
            next_st.fsm = ST_IDLE;
          end else begin
            next_st.fsm = ST_RD_SRC;
          end
        end
      end
      ST_RD_SRC: begin
        if (ack) begin
          next_st.src_end = m_readdata_i;
          next_st.fsm     = ST_RD_DST;
        end
      end
      ST_RD_DST: begin
        if (ack) begin
          next_st.dst_end = m_readdata_i;
          next_st.fsm     = ST_RD_DAT;
          if (!st.burst) begin
            next_st.left = CNT_ONE;
          end else if (arb_cnt < remain) begin
            next_st.left = arb_cnt;
          end else begin
            next_st.left = remain;
          end
        end
      end
      ST_RD_DAT: begin
        if (ack) begin
          next_st.data = item;
          next_st.fsm  = ST_WR_DAT;
        end
      end
      ST_WR_DAT: begin
        if (ack) begin
          next_st.left = st.left - CNT_ONE;
          if (nm1 == 10'h000) begin
            next_st.ctl[CW_MODE_LSB +: CW_MODE_W] = MODE_STOP;
            next_st.fsm = ST_WB;
          end else begin
            next_st.ctl[CW_NM1_LSB +: CW_NM1_W] = nm1 - 10'h001;
            // no re-arbitration until the burst count runs out
            next_st.fsm = (st.left == CNT_ONE) ? ST_WB : ST_RD_DAT;
          end
        end
      end
      ST_WB: begin
        if (ack) begin
          next_st.fsm = ST_IDLE;
          if (st.ctl[CW_MODE_LSB +: CW_MODE_W] == MODE_STOP) begin
            next_st.en[st.ch]   = 1'b0;
            next_st.done[st.ch] = 1'b1;
          end
        end
      end
      default: next_st.fsm = ST_IDLE;
    endcase

    // register slave; software set comes last so it wins
    if ((s_read_i || s_write_i) && st.s_wait) begin
      next_st.s_wait  = 1'b0;
      next_st.s_rdata = '0;
      if (s_address_i == REG_BASE) begin
        next_st.s_rdata = {st.base, 8'h00};
        if (s_write_i) begin
          next_st.base = s_writedata_i[31:BASE_LSB];
        end
      end else if (s_address_i == REG_EN_SET ||
                   s_address_i == REG_EN_CLR) begin
        next_st.s_rdata[CH_N-1:0] = st.en;
        if (s_write_i && s_address_i == REG_EN_SET) begin
          next_st.en = next_st.en | s_writedata_i[CH_N-1:0];
        end else if (s_write_i) begin
          next_st.en = next_st.en & ~s_writedata_i[CH_N-1:0];
        end
      end else if (s_address_i == REG_PRI_SET ||
                   s_address_i == REG_PRI_CLR) begin
        next_st.s_rdata[CH_N-1:0] = st.pri;
        if (s_write_i && s_address_i == REG_PRI_SET) begin
          next_st.pri = st.pri | s_writedata_i[CH_N-1:0];
        end else if (s_write_i) begin
          next_st.pri = st.pri & ~s_writedata_i[CH_N-1:0];
        end
      end else if (s_address_i == REG_BO_SET ||
                   s_address_i == REG_BO_CLR) begin
        next_st.s_rdata[CH_N-1:0] = st.bonly;
        if (s_write_i && s_address_i == REG_BO_SET) begin
          next_st.bonly = st.bonly | s_writedata_i[CH_N-1:0];
        end else if (s_write_i) begin
          next_st.bonly = st.bonly & ~s_writedata_i[CH_N-1:0];
        end
      end else if (s_address_i == REG_ALT_SET ||
                   s_address_i == REG_ALT_CLR) begin
        next_st.s_rdata[CH_N-1:0] = st.alt;
        if (s_write_i && s_address_i == REG_ALT_SET) begin
          next_st.alt = st.alt | s_writedata_i[CH_N-1:0];
        end else if (s_write_i) begin
          next_st.alt = st.alt & ~s_writedata_i[CH_N-1:0];
        end
      end else if (s_address_i == REG_STATUS) begin
        next_st.s_rdata[7:0] = {acc_state, st.fsm, 1'b0, st.ch};
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      st        <= '0;
      st.s_wait <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign s_readdata_o    = st.s_rdata;
  assign s_waitrequest_o = st.s_wait;
  assign m_req_o         = st.mm;
  assign done_o          = st.done;

  // ==========================================================
  // checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  AST_CPU_WINS: assert property (
    ($rose(m_req_o.read) || $rose(m_req_o.write)) |->
      !$past(cpu_bus_req_i))
    else $error("access launched while processor held the bus");

  AST_ONE_DIR: assert property (!(m_req_o.read && m_req_o.write))
    else $error("master read and write together");

  AST_HOLD_REQ: assert property (
    (m_req_o.read && m_waitrequest_i) |=>
      (m_req_o.read && $stable(m_req_o.address)))
    else $error("read request dropped while stalled");

  AST_PRI_CLR: assert property (
    (s_write_i && s_waitrequest_o && s_address_i == REG_PRI_CLR) |=>
      ((st.pri & $past(s_writedata_i[CH_N-1:0])) == '0))
    else $error("priority clear did not clear");

  AST_EN_SET: assert property (
    (s_write_i && s_waitrequest_o && s_address_i == REG_EN_SET) |=>
      ((st.en & $past(s_writedata_i[CH_N-1:0])) ==
       $past(s_writedata_i[CH_N-1:0])))
    else $error("enable set lost");

  AST_AUTO_DISABLE: assert property (
    (|done_o && !$past(s_write_i)) |-> ((st.en & done_o) == '0))
    else $error("finished channel still enabled");

  AST_NO_PTR_WRITE: assert property (
    (m_req_o.write && st.fsm == ST_WB) |->
      (m_req_o.address == entry + OFF_CTL))
    else $error("write-back aimed outside the control word");

  AST_SINGLE_ONE: assert property (
    (st.fsm == ST_RD_DAT && $past(st.fsm) == ST_RD_DST && !st.burst) |->
      (st.left == CNT_ONE))
    else $error("single request not one item");

  AST_BURST_LEN: assert property (
    (st.fsm == ST_RD_DAT && $past(st.fsm) == ST_RD_DST) |->
      (st.left <= arb_cnt && st.left <= remain))
    else $error("burst longer than arbitration size or remainder");

  AST_SLV_PULSE: assert property (!s_waitrequest_o |=> s_waitrequest_o)
    else $error("slave answer longer than one cycle");

  COV_BURST_DONE: cover property (st.burst && |done_o);
  COV_SINGLE: cover property (st.fsm == ST_WB && !st.burst);
  COV_STOP: cover property (st.fsm == ST_RD_CTL && ack &&
    m_readdata_i[CW_MODE_LSB +: CW_MODE_W] == MODE_STOP);
  COV_STALL: cover property (acc_state && cpu_bus_req_i &&
    !m_req_o.read && !m_req_o.write);

endmodule

// ---- tb/dca_mem_model.sv ----
// dca_mem_model: word memory answering the controller's master port.
// assumes byte addresses below 0x400; stall_i sets the answer latency.
`timescale 1ns/10ps
module dca_mem_model (
  // clock and reset
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  // master port of the controller
  input  wire dca_pkg::dca_mm_req_t req_i,
  output logic      [31:0]          readdata_o,
  output logic                      waitrequest_o,
  // latency control
  input  wire logic [3:0]           stall_i
);
  import dca_pkg::*;
  logic [31:0] mem [256];
  logic [3:0]  cnt;

  // ==========================================================
  // slave: one answer cycle after stall_i + 1 waiting cycles
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      waitrequest_o <= 1'b1;
      cnt           <= 4'h0;
      readdata_o    <= 32'h0000_0000;
    end else if (!waitrequest_o) begin
      // answer taken; data inverted so stale values never pass
      waitrequest_o <= 1'b1;
      cnt           <= 4'h0;
      readdata_o    <= ~readdata_o;
      if (req_i.write) begin
        for (int b = 0; b < 4; b++) begin
          if (req_i.byteenable[b]) begin
            mem[req_i.address[9:2]][b*8 +: 8] <= req_i.writedata[b*8 +: 8];
          end
        end
      end
    end else if (req_i.read || req_i.write) begin
      if (cnt >= stall_i) begin
        waitrequest_o <= 1'b0;
        readdata_o    <= req_i.read ? mem[req_i.address[9:2]] : ~readdata_o;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ---- tb/tb.sv ----
// tb: register and transfer tests of the channel controller.
// assumes dca_mem_model on the master port; table at 0x100.
`timescale 1ns/10ps
module tb;
  import dca_pkg::*;
  localparam int TBL = 32'h0000_0100;
  localparam int SRC = 32'h0000_0200;
  localparam int DST = 32'h0000_0300;

  logic              clock_i         = 1'b0;
  logic              rst_i           = 1'b1;
  logic [7:0]        s_address_i     = 8'h00;
  logic              s_read_i        = 1'b0;
  logic              s_write_i       = 1'b0;
  logic [31:0]       s_writedata_i   = 32'h0000_0000;
  logic [31:0]       s_readdata_o;
  logic              s_waitrequest_o;
  dca_mm_req_t       m_req_o;
  logic [31:0]       m_readdata_i;
  logic              m_waitrequest_i;
  logic              cpu_bus_req_i   = 1'b0;
  dca_req_t          req_i           = '0;
  logic [CH_N-1:0]   done_o;
  logic [3:0]        stall           = 4'h0;
  int                n_mismatch      = 0;
  int                checks_done     = 0;
  int                n_wr            = 0;
  int                n_wb            = 0;
  int                cpu_viol        = 0;
  int                done_cnt [CH_N] = '{default: 0};
  logic [3:0]        wr_seq [$];
  logic              prev_acc        = 1'b0;
  logic              prev_cpu        = 1'b0;

  always #2 clock_i = ~clock_i;

  dca_ctrl dut (
    .clock_i(clock_i), .rst_i(rst_i), .s_address_i(s_address_i),
    .s_read_i(s_read_i), .s_write_i(s_write_i),
    .s_writedata_i(s_writedata_i), .s_readdata_o(s_readdata_o),
    .s_waitrequest_o(s_waitrequest_o), .m_req_o(m_req_o),
    .m_readdata_i(m_readdata_i), .m_waitrequest_i(m_waitrequest_i),
    .cpu_bus_req_i(cpu_bus_req_i), .req_i(req_i), .done_o(done_o));

  dca_mem_model mdl (
    .clock_i(clock_i), .rst_i(rst_i), .req_i(m_req_o),
    .readdata_o(m_readdata_i), .waitrequest_o(m_waitrequest_i),
    .stall_i(stall));

  // ==========================================================
  // bus monitor
  always @(posedge clock_i) begin
    prev_acc <= m_req_o.read | m_req_o.write;
    prev_cpu <= cpu_bus_req_i;
    if ((m_req_o.read | m_req_o.write) && !prev_acc && prev_cpu) begin
      cpu_viol++;
    end
    if (m_req_o.write && !m_waitrequest_i) begin
      if (m_req_o.address[9:8] == 2'h3) begin
        wr_seq.push_back(m_req_o.address[7:4]);
        n_wr++;
      end
      if (m_req_o.address[9:8] == 2'h1) begin
        n_wb++;
      end
    end
    for (int c = 0; c < CH_N; c++) begin
      if (done_o[c] === 1'b1) begin
        done_cnt[c]++;
      end
    end
  end

  // ==========================================================
  // tasks
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_acc(input logic wr, input logic [7:0] a,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    s_address_i   <= a;
    s_writedata_i <= d;
    s_write_i     <= wr;
    s_read_i      <= !wr;
    // request taken at the first edge, answer seen at the second
    do begin
      @(posedge clock_i);
      n++;
    end while (s_waitrequest_o !== 1'b0);
    q = s_readdata_o;
    s_write_i <= 1'b0;
    s_read_i  <= 1'b0;
    check("register answer", 32'(n), 32'h0000_0002);
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    reg_acc(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string w, input logic [7:0] a,
                        input logic [31:0] e);
    logic [31:0] q;
    reg_acc(1'b0, a, 32'h0000_0000, q);
    check(w, q, e);
  endtask

  function automatic int cur(input int sel);
    return sel < CH_N ? done_cnt[sel] : (sel == 8 ? n_wr : n_wb);
  endfunction

  // sel: channel number for done pulses, 8 dest writes, 9 write-backs
  task automatic wait_ev(input int sel, k);
    for (int i = 0; i < 3000 && cur(sel) < k; i++) begin
      @(posedge clock_i);
    end
    check("event count", 32'(cur(sel)), 32'(k));
  endtask

  function automatic logic [31:0] mkctl(input int nm1, arb, mode);
    return 32'hAA00_0000 | 32'(nm1) << 4 | 32'(arb) << 14 | 32'(mode);
  endfunction

  function automatic logic [31:0] val(input int c, i, mark);
    return (mark != 0 ? 32'h0BAD_0000 : 32'hA5C3_0000) | 32'(c * 256 + i);
  endfunction

  task automatic setup(input int c, alt, n, arb, mode);
    int t;
    t = (TBL + alt * 128 + c * 16) / 4;
    mdl.mem[t]   = 32'(SRC + c * 16 + n * 4 - 4);
    mdl.mem[t+1] = 32'(DST + c * 16 + n * 4 - 4);
    mdl.mem[t+2] = mkctl(n - 1, arb, mode);
    for (int i = 0; i < 4; i++) begin
      mdl.mem[(SRC + c * 16) / 4 + i] = val(c, i, 0);
      mdl.mem[(DST + c * 16) / 4 + i] = val(c, i, 1);
    end
    n_wr = 0;
    n_wb = 0;
    wr_seq.delete();
  endtask

  task automatic post(input int c, alt, n, arb, nm1, mode, moved);
    int t;
    t = (TBL + alt * 128 + c * 16) / 4;
    check("src end", mdl.mem[t], 32'(SRC + c * 16 + n * 4 - 4));
    check("dst end", mdl.mem[t+1], 32'(DST + c * 16 + n * 4 - 4));
    check("ctl word", mdl.mem[t+2], mkctl(nm1, arb, mode));
    for (int i = 0; i < 4; i++) begin
      check("dest item", mdl.mem[(DST + c * 16) / 4 + i],
            val(c, i, 32'(i >= moved)));
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end

  // ==========================================================
  // test sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mdl.mem[i] = 32'h0000_0000;
    end
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    for (int a = 0; a <= 8'h28; a += 4) begin
      rd_chk("reset value", 8'(a), 32'h0000_0000);
    end
    wr(8'h3C, 32'hFFFF_FFFF);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    wr(REG_PRI_SET, 32'h0000_0005);
    rd_chk("priority", REG_PRI_SET, 32'h0000_0005);
    wr(REG_PRI_CLR, 32'h0000_0001);
    rd_chk("priority", REG_PRI_SET, 32'h0000_0004);
    wr(REG_PRI_CLR, 32'h0000_0004);
    wr(REG_BASE, 32'h0000_01FF);
    rd_chk("base", REG_BASE, 32'h0000_0100);
    // single then burst on channel 2, arbitration size 4
    stall <= 4'h1;
    setup(2, 0, 3, 2, 1);
    wr(REG_EN_SET, 32'h0000_0004);
    rd_chk("enable", REG_EN_SET, 32'h0000_0004);
    req_i.single[2] <= 1'b1;
    wait_ev(8, 1);
    req_i.single[2] <= 1'b0;
    wait_ev(9, 1);
    repeat (30) @(posedge clock_i);
    check("single items", 32'(n_wr), 32'h0000_0001);
    post(2, 0, 3, 2, 1, 1, 1);
    req_i.burst[2] <= 1'b1;
    wait_ev(2, 1);
    req_i.burst[2] <= 1'b0;
    check("burst items", 32'(n_wr), 32'h0000_0003);
    post(2, 0, 3, 2, 0, 0, 3);
    rd_chk("auto disable", REG_EN_SET, 32'h0000_0000);
    // channel 4: alternate structure, burst only, size 2 of 4
    stall <= 4'h2;
    wr(REG_ALT_SET, 32'h0000_0010);
    wr(REG_BO_SET, 32'h0000_0010);
    rd_chk("burst only", REG_BO_SET, 32'h0000_0010);
    setup(4, 1, 4, 1, 1);
    wr(REG_EN_SET, 32'h0000_0010);
    req_i.single[4] <= 1'b1;
    repeat (40) @(posedge clock_i);
    check("ignored single", 32'(n_wr + n_wb), 32'h0000_0000);
    req_i.burst[4] <= 1'b1;
    wait_ev(8, 2);
    req_i <= '0;
    wait_ev(9, 1);
    repeat (20) @(posedge clock_i);
    check("burst items", 32'(n_wr), 32'h0000_0002);
    post(4, 1, 4, 1, 1, 1, 2);
    wr(REG_EN_CLR, 32'h0000_0010);
    rd_chk("enable clear", REG_EN_SET, 32'h0000_0000);
    wr(REG_BO_CLR, 32'h0000_0010);
    wr(REG_ALT_CLR, 32'h0000_0010);
    // channels 5 and 6 requesting together, with and without priority
    stall <= 4'h0;
    for (int r = 0; r < 2; r++) begin
      setup(5, 0, 2, 1, 1);
      setup(6, 0, 2, 1, 1);
      wr(r == 0 ? REG_PRI_SET : REG_PRI_CLR, 32'h0000_0040);
      wr(REG_EN_SET, 32'h0000_0060);
      req_i.burst <= 8'h60;
      wait_ev(5, r + 1);
      wait_ev(6, r + 1);
      req_i.burst <= 8'h00;
      check("first winner", 32'(wr_seq[0]), r == 0 ? 6 : 5);
      check("burst kept", 32'(wr_seq[1]), r == 0 ? 6 : 5);
      check("second winner", 32'(wr_seq[2]), r == 0 ? 5 : 6);
    end
    // long low burst, processor busy mid-burst, higher channel waits
    stall <= 4'h1;
    setup(6, 0, 4, 2, 1);
    setup(3, 0, 1, 0, 1);
    wr(REG_EN_SET, 32'h0000_0048);
    req_i.burst[6] <= 1'b1;
    wait_ev(8, 1);
    cpu_bus_req_i <= 1'b1;
    req_i.burst[3] <= 1'b1;
    repeat (20) @(posedge clock_i);
    check("stalled by cpu", 32'(n_wr), 32'h0000_0001);
    cpu_bus_req_i <= 1'b0;
    wait_ev(3, 1);
    req_i.burst <= 8'h00;
    for (int i = 0; i < 4; i++) begin
      check("uninterrupted", 32'(wr_seq[i]), 32'h0000_0006);
    end
    check("after burst", 32'(wr_seq[4]), 32'h0000_0003);
    check("cpu launches", 32'(cpu_viol), 32'h0000_0000);
    // channel 0: useburst word ignores single, burst beside single moves
    setup(0, 0, 1, 0, 9);
    wr(REG_EN_SET, 32'h0000_0001);
    req_i.single[0] <= 1'b1;
    repeat (40) @(posedge clock_i);
    check("useburst single", 32'(n_wr + n_wb), 32'h0000_0000);
    req_i.burst[0] <= 1'b1;
    wait_ev(0, 1);
    req_i <= '0;
    post(0, 0, 1, 0, 0, 8, 1);
    // channel 1: byte items from lanes 2 and 3 into lanes 0 and 1
    setup(1, 0, 2, 1, 1);
    mdl.mem[(TBL + 16) / 4]     = 32'(SRC + 19);
    mdl.mem[(TBL + 16) / 4 + 1] = 32'(DST + 17);
    mdl.mem[(TBL + 16) / 4 + 2] = 32'h0000_4011;
    wr(REG_EN_SET, 32'h0000_0002);
    req_i.burst[1] <= 1'b1;
    wait_ev(1, 1);
    req_i <= '0;
    check("byte items", mdl.mem[(DST + 16) / 4], 32'h0BAD_A5C3);
    check("byte ctl", mdl.mem[(TBL + 16) / 4 + 2], 32'h0000_4000);
    // stop mode: nothing moved, channel disabled
    setup(7, 0, 2, 0, 0);
    wr(REG_EN_SET, 32'h0000_0080);
    req_i.burst[7] <= 1'b1;
    repeat (40) @(posedge clock_i);
    req_i.burst[7] <= 1'b0;
    rd_chk("stop disable", REG_EN_SET, 32'h0000_0000);
    check("stop items", 32'(n_wr + n_wb), 32'h0000_0000);
    post(7, 0, 2, 0, 1, 0, 0);
    summarize();
  end
endmodule
